// *** verilog/spi_eeprom_cmd.sv ***
// serial eeprom slave: pin sampling, command decode, status, write timer
// Summary of operation
// [RULE1] serial input bits are captured on rising serial clock in both modes
// [RULE2] serial output moves to its next bit on falling serial clock
// [RULE3] chip select high: output released; standby unless write cycle runs
// [RULE4] chip select falling opens a session, rising closes it
// [RULE5] protect pin high never blocks any write
// [RULE6] protect pin low with protect enable set rejects status writes
// [RULE7] pause input low freezes the transfer; clock low at its edges
// [RULE8] a pause keeps the position inside the current sequence
// [RULE9] hosts that never pause tie the pause input high
// [RULE10] first eight bits after chip select falls form the instruction
// [RULE11] only six instructions act; any other value is disregarded
// [RULE12] 06 sets write latch, 04 clears it, 05 reads status
// [RULE13] 01 writes status, 03 reads memory, 02 writes memory
// [RULE14] memory read is opcode plus address, then data streams out
// [RULE15] memory write needs opcode, address, data and a set write latch
// [RULE16] page select set redirects accesses to the 256-byte id page
// [RULE17] the id page can be locked against writes for good
// [RULE18] each four-byte group carries six correcting check bits
// [RULE19] a byte write reprograms its whole group with check bits
// [RULE20] self-timed write ends within 5 ms of the closing chip select
// [RULE21] host waits 1 ms after power is stable before access; the bench waits PWR_UP_CYC (64) clocks after reset
// [RULE22] status: enable 7, page select 6, lock 4, protect 3:2, latch 1, busy 0
// [RULE23] write latch set by its set opcode, cleared by its clear opcode
// [RULE24] during a write cycle only status read is obeyed
// [RULE25] data opcodes take 24 address bits; main array uses low 17
// [RULE26] after an unknown opcode, ignore input and release output
`timescale 1ns/1ps
module spi_eeprom_cmd
  import eeprom_spi_pkg::*;
#(
  parameter int unsigned WC_CYC = WRITE_CYCLE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // array read port, data follows address combinationally
  output logic [14:0] mem_raddr,
  output logic mem_rid,
  input wire ecc_word_s mem_rdata,
  // array write port
  output logic mem_we,
  output logic [14:0] mem_waddr,
  output logic mem_wid,
  output ecc_word_s mem_wdata,
  // status
  output logic [7:0] status,
  output logic write_busy
);
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic sck_d_r;
  logic cs_d_r;
  logic cs_s, sck_s, si_s, hold_s, wp_s;
  logic live, sck_rise, sck_fall, cs_rise;
  sess_state_e st_r, st_nxt, opc_st;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] sh_r, in_byte, osh_r, out_byte, rd_byte;
  logic byte_end, addr_end, out_st;
  logic is_cmd_set_write_latch, is_cmd_clear_write_latch, is_cmd_read_status, is_cmd_write_status, is_rd, is_wr;
  logic wsr_ok, wr_ok, wr_op_r, id_r;
  logic [16:0] addr_r, addr_shift, addr_load, addr_inc;
  logic prot_main, prot_hit;
  logic so_r, so_oe_r, drv_r;
  logic pen_r, ips_r, lock_r, wel_r, busy_r;
  logic [1:0] bp_r;
  logic [7:0] status_w, wsr_byte_r;
  logic act_cmd_set_write_latch_r, act_cmd_clear_write_latch_r, act_wsr_r, act_rw_r;
  logic both_id, start_wc, wc_done;
  logic [WC_W-1:0] wc_cnt_r;
  logic [31:0] gbuf_r, merged_w, dec_data;
  logic [14:0] gaddr_r, mem_waddr_r;
  logic gpend_r, dirty_r, wr_any_r, wr_byte, lane_last, flush;
  logic mem_we_r, mem_wid_r;
  logic [5:0] enc_check;
  ecc_word_s mem_wdata_r;

  // pins come from the host's domain: two flops before any use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      pin_meta_r <= {cs_n, sck, si, hold_n, wp_n};
      pin_sync_r <= pin_meta_r;
      sck_d_r <= pin_sync_r[3];
      cs_d_r <= pin_sync_r[4];
    end
  end

  assign cs_s = pin_sync_r[4];
  assign sck_s = pin_sync_r[3];
  assign si_s = pin_sync_r[2];
  assign hold_s = pin_sync_r[1];
  assign wp_s = pin_sync_r[0];
  // clock edges seen during a pause are dropped, so the position holds
  assign live = ~cs_s & hold_s; // RULE7 RULE8
  assign sck_rise = live & sck_s & ~sck_d_r; // RULE1
  assign sck_fall = live & ~sck_s & sck_d_r; // RULE2
  assign cs_rise = cs_s & ~cs_d_r; // RULE4

  // instruction decode
  assign in_byte = {sh_r[6:0], si_s};
  assign byte_end = bit_r[2:0] == BYTE_LAST;
  assign addr_end = bit_r == ADDR_LAST;
  assign is_cmd_set_write_latch = in_byte == OP_SET_LATCH; // RULE12
  assign is_cmd_clear_write_latch = in_byte == OP_CLR_LATCH; // RULE12
  assign is_cmd_read_status = in_byte == OP_RD_STAT; // RULE12
  assign is_cmd_write_status = in_byte == OP_WR_STAT; // RULE13
  assign is_rd = in_byte == OP_RD_MEM; // RULE13
  assign is_wr = in_byte == OP_WR_MEM; // RULE13
  assign wsr_ok = wel_r & (wp_s | ~pen_r); // RULE5 RULE6
  assign wr_ok = is_wr & wel_r; // RULE15
  assign opc_st = (busy_r & ~is_cmd_read_status) ? ST_IGNORE : // RULE24
                  is_cmd_read_status ? ST_RSTAT :
                  (is_cmd_write_status & wsr_ok) ? ST_WSTAT :
                  (is_rd | wr_ok) ? ST_ADDR :
                  ST_IGNORE; // RULE11 RULE26

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OPC: if (byte_end) st_nxt = opc_st; // RULE10
      ST_ADDR: if (addr_end) begin // RULE14 RULE15
        if (!wr_op_r)
          st_nxt = ST_RDATA;
        else if (prot_hit)
          st_nxt = ST_IGNORE;
        else
          st_nxt = ST_WDATA;
      end
      ST_WSTAT: if (byte_end) st_nxt = ST_IGNORE;
      ST_IDLE, ST_RDATA, ST_WDATA, ST_RSTAT, ST_IGNORE: st_nxt = st_r;
      default: st_nxt = ST_IDLE;
    endcase
  end

  assign bit_nxt = (st_r == ST_ADDR) ? (addr_end ? 5'h00 : bit_r + 5'h01)
                                     : {2'b00, bit_r[2:0] + 3'h1};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      bit_r <= 5'h00;
      sh_r <= 8'h00;
    end else if (cs_s) begin
      st_r <= ST_IDLE; // RULE4
      bit_r <= 5'h00;
    end else if (st_r == ST_IDLE) begin
      st_r <= ST_OPC; // RULE4 RULE10
    end else if (sck_rise) begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= in_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_op_r <= 1'b0;
      id_r <= 1'b0;
    end else if (sck_rise && st_r == ST_OPC && byte_end) begin
      wr_op_r <= is_wr;
      id_r <= ips_r; // RULE16
    end
  end

  // address: 24 clocks, only the low 17 kept, 8 on the id page
  assign addr_shift = {addr_r[15:0], si_s};
  assign addr_load = id_r ? {9'h000, addr_shift[7:0]} : addr_shift; // RULE16
  assign addr_inc = (id_r || st_r == ST_WDATA) ?
                    {addr_r[16:8], addr_r[7:0] + 8'h01} : addr_r + 17'h00001;
  assign prot_main = (bp_r == 2'h3) || (bp_r == 2'h2 && addr_load[16]) ||
                     (bp_r == 2'h1 && addr_load[16] && addr_load[15]);
  assign prot_hit = id_r ? (lock_r || bp_r == 2'h3) : prot_main; // RULE17

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      addr_r <= 17'h00000;
    else if (sck_rise && st_r == ST_ADDR)
      addr_r <= addr_end ? addr_load : addr_shift; // RULE25
    else if (sck_rise && byte_end && (st_r == ST_RDATA || st_r == ST_WDATA))
      addr_r <= addr_inc;
  end

  // output shifter; a byte is fetched at the first fall of each byte
  assign out_st = st_r == ST_RDATA || st_r == ST_RSTAT;
  assign rd_byte = dec_data[{addr_r[1:0], 3'b000} +: 8];
  assign out_byte = (st_r == ST_RSTAT) ? status_w : rd_byte;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_r <= 1'b0;
      osh_r <= 8'h00;
      drv_r <= 1'b0;
    end else if (cs_s) begin
      drv_r <= 1'b0; // RULE3
    end else if (sck_fall && out_st) begin
      if (bit_r[2:0] == 3'h0) begin
        so_r <= out_byte[7]; // RULE2 RULE14
        osh_r <= {out_byte[6:0], 1'b0};
        drv_r <= 1'b1;
      end else begin
        so_r <= osh_r[7]; // RULE2
        osh_r <= {osh_r[6:0], 1'b0};
      end
    end
  end

  // released while deselected, paused or ignoring the rest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      so_oe_r <= 1'b0;
    else
      so_oe_r <= drv_r & hold_s & ~cs_s; // RULE3 RULE7 RULE26
  end

  // group buffer: bytes merge into the corrected old group, which is
  // rewritten whole, so a lone byte still costs a full group program
  ecc_group u_ecc (
    .enc_data(merged_w),
    .enc_check(enc_check),
    .dec_word(mem_rdata),
    .dec_data(dec_data),
    .dec_fixed()
  ); // RULE18

  assign wr_byte = sck_rise & (st_r == ST_WDATA) & byte_end;
  assign lane_last = addr_r[1:0] == 2'h3;
  assign flush = (wr_byte & lane_last) | (cs_rise & dirty_r); // RULE19

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_lane
      assign merged_w[8*k +: 8] = (wr_byte && addr_r[1:0] == 2'(k)) ?
                                  in_byte : gbuf_r[8*k +: 8];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_r <= 1'b0;
      mem_waddr_r <= 15'h0000;
      mem_wid_r <= 1'b0;
      mem_wdata_r <= '0;
    end else begin
      mem_we_r <= flush;
      if (flush) begin
        mem_waddr_r <= gaddr_r;
        mem_wid_r <= id_r;
        mem_wdata_r <= {enc_check, merged_w}; // RULE18 RULE19
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gbuf_r <= 32'h00000000;
      gaddr_r <= 15'h0000;
      gpend_r <= 1'b0;
      dirty_r <= 1'b0;
      wr_any_r <= 1'b0;
    end else begin
      if (gpend_r) begin
        gbuf_r <= dec_data;
        gaddr_r <= addr_r[16:2];
      end else if (wr_byte) begin
        gbuf_r <= merged_w;
      end
      gpend_r <= (sck_rise & (st_r == ST_ADDR) & addr_end & wr_op_r) |
                 (wr_byte & lane_last);
      dirty_r <= flush ? 1'b0 : (dirty_r | wr_byte);
      wr_any_r <= (st_r == ST_IDLE) ? 1'b0 : (wr_any_r | wr_byte);
    end
  end

  // actions armed in the session, carried out at chip select rising
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cmd_set_write_latch_r <= 1'b0;
      act_cmd_clear_write_latch_r <= 1'b0;
      act_wsr_r <= 1'b0;
      act_rw_r <= 1'b0;
      wsr_byte_r <= STAT_RST;
    end else if (st_r == ST_IDLE) begin
      act_cmd_set_write_latch_r <= 1'b0;
      act_cmd_clear_write_latch_r <= 1'b0;
      act_wsr_r <= 1'b0;
      act_rw_r <= 1'b0;
    end else if (sck_rise && st_r == ST_OPC && byte_end && !busy_r) begin
      act_cmd_set_write_latch_r <= is_cmd_set_write_latch; // RULE23
      act_cmd_clear_write_latch_r <= is_cmd_clear_write_latch; // RULE23
      act_rw_r <= is_rd | wr_ok;
    end else if (sck_rise && st_r == ST_WSTAT && byte_end) begin
      act_wsr_r <= 1'b1;
      wsr_byte_r <= in_byte;
    end
  end

  // page select and lock together in one write leave both untouched
  assign both_id = wsr_byte_r[SB_IPS] & wsr_byte_r[SB_LOCK];
  assign start_wc = cs_rise & (act_wsr_r | wr_any_r | dirty_r); // RULE20
  assign wc_done = busy_r && (wc_cnt_r == WC_W'(WC_CYC - 1)); // RULE20

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pen_r, ips_r, lock_r, bp_r, wel_r} <= {STAT_RST[7:6], STAT_RST[4:1]};
      busy_r <= STAT_RST[SB_BUSY];
      wc_cnt_r <= '0;
    end else if (busy_r) begin
      wc_cnt_r <= wc_done ? '0 : wc_cnt_r + WC_W'(1);
      if (wc_done) begin
        busy_r <= 1'b0; // RULE20
        wel_r <= 1'b0; // RULE15
      end
    end else if (cs_rise) begin
      busy_r <= start_wc; // RULE3
      if (act_cmd_set_write_latch_r)
        wel_r <= 1'b1; // RULE23
      if (act_cmd_clear_write_latch_r)
        wel_r <= 1'b0; // RULE23
      if (act_rw_r)
        ips_r <= 1'b0; // RULE16
      if (act_wsr_r) begin
        pen_r <= wsr_byte_r[SB_PEN]; // RULE6
        bp_r <= wsr_byte_r[SB_BP_HI:SB_BP_LO];
        ips_r <= both_id ? ips_r : wsr_byte_r[SB_IPS]; // RULE16
        lock_r <= lock_r | (wsr_byte_r[SB_LOCK] & ~both_id); // RULE17
      end
    end
  end

  assign status_w = {pen_r, ips_r, 1'b0, lock_r, bp_r, wel_r, busy_r}; // RULE22

  assign so = so_r;
  assign so_oe = so_oe_r;
  assign mem_raddr = addr_r[16:2];
  assign mem_rid = id_r;
  assign mem_we = mem_we_r;
  assign mem_waddr = mem_waddr_r;
  assign mem_wid = mem_wid_r;
  assign mem_wdata = mem_wdata_r;
  assign status = status_w;
  assign write_busy = busy_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  desel_release_a: assert property (cs_s |=> !so_oe_r) // RULE3
    else $error("output driven while deselected");
  pause_release_a: assert property (!hold_s |=> !so_oe_r) // RULE7
    else $error("output driven during pause");
  pause_freeze_a: assert property (!hold_s && !cs_s |=> $stable(bit_r)) // RULE8
    else $error("bit position moved during pause");
  so_fall_a: assert property ($changed(so_r) |-> $past(sck_fall)) // RULE2
    else $error("serial output changed off a falling edge");
  ignore_quiet_a: assert property (st_r == ST_IGNORE |-> !drv_r) // RULE26
    else $error("output armed after unknown opcode");
  busy_ignore_a: assert property (sck_rise && st_r == ST_OPC && byte_end && // RULE24
      busy_r && !is_cmd_read_status |=> st_r == ST_IGNORE)
    else $error("opcode obeyed during write cycle");
  read_addr_a: assert property (sck_rise && st_r == ST_OPC && byte_end && // RULE13
      is_rd && !busy_r |=> st_r == ST_ADDR)
    else $error("read opcode not decoded");
  wsr_block_a: assert property (sck_rise && st_r == ST_OPC && byte_end && // RULE6
      is_cmd_write_status && !wp_s && pen_r |=> st_r != ST_WSTAT)
    else $error("status write passed protect pin");
  wc_length_a: assert property ($fell(busy_r) |-> // RULE20
      $past(wc_cnt_r) == WC_W'(WC_CYC - 1) && !wel_r)
    else $error("write cycle length wrong");
  latch_set_a: assert property (cs_rise && act_cmd_set_write_latch_r && !busy_r |=> // RULE23
      wel_r)
    else $error("write latch not set");
  group_flush_a: assert property (wr_byte && lane_last |=> mem_we_r) // RULE19
    else $error("full group not written");

  read_cov_c: cover property (sck_fall && st_r == ST_RDATA && drv_r);
  stat_cov_c: cover property (sck_fall && st_r == ST_RSTAT && busy_r);
  flush_cov_c: cover property (mem_we_r ##1 cs_s);
  wsr_cov_c: cover property (cs_rise && act_wsr_r);
endmodule

// *** verilog/eeprom_spi_pkg.sv ***
// constants and types shared by the serial eeprom command interface
package eeprom_spi_pkg;
  // instruction codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD_MEM = 8'h03;
  localparam logic [7:0] OP_WR_MEM = 8'h02;
  // status bit positions
  localparam int SB_PEN = 7;
  localparam int SB_IPS = 6;
  localparam int SB_LOCK = 4;
  localparam int SB_BP_HI = 3;
  localparam int SB_BP_LO = 2;
  localparam int SB_WEL = 1;
  localparam int SB_BUSY = 0;
  localparam logic [7:0] STAT_RST = 8'h00;
  // framing
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] PIN_IDLE = 5'h13;
  // ecc group layout
  localparam int CW_BITS = 38;
  // self-timed write cycle
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int WC_W = 20;

  typedef struct packed {
    logic [5:0] check;
    logic [31:0] data;
  } ecc_word_s;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPC = 8'h02,
    ST_ADDR = 8'h04,
    ST_RDATA = 8'h08,
    ST_WDATA = 8'h10,
    ST_RSTAT = 8'h20,
    ST_WSTAT = 8'h40,
    ST_IGNORE = 8'h80
  } sess_state_e;
endpackage

// *** verilog/ecc_group.sv ***
// single-error-correcting code over one four-byte group
`timescale 1ns/1ps
module ecc_group
  import eeprom_spi_pkg::*;
(
  // encoder
  input wire logic [31:0] enc_data,
  output logic [5:0] enc_check,
  // decoder
  input wire ecc_word_s dec_word,
  output logic [31:0] dec_data,
  output logic dec_fixed
);
  // check bits sit at the power-of-two positions of the code word
  function automatic logic [37:0] place(input logic [31:0] d,
                                        input logic [5:0] p);
    int di;
    int pi;
    logic [37:0] cw;
    di = 0;
    pi = 0;
    cw = '0;
    for (int j = 1; j <= CW_BITS; j++) begin
      if ((j & (j - 1)) == 0) begin
        cw[j - 1] = p[pi];
        pi++;
      end else begin
        cw[j - 1] = d[di];
        di++;
      end
    end
    return cw;
  endfunction

  function automatic logic [31:0] extract(input logic [37:0] cw);
    int di;
    logic [31:0] d;
    di = 0;
    d = '0;
    for (int j = 1; j <= CW_BITS; j++) begin
      if ((j & (j - 1)) != 0) begin
        d[di] = cw[j - 1];
        di++;
      end
    end
    return d;
  endfunction

  function automatic logic [5:0] syndrome(input logic [37:0] cw);
    logic [5:0] s;
    s = '0;
    for (int j = 1; j <= CW_BITS; j++) begin
      if (cw[j - 1])
        s = s ^ 6'(j);
    end
    return s;
  endfunction

  logic [37:0] raw_cw;
  logic [37:0] fix_cw;
  logic [5:0] syn;

  assign enc_check = syndrome(place(enc_data, 6'h00));
  assign raw_cw = place(dec_word.data, dec_word.check);
  assign syn = syndrome(raw_cw);
  assign dec_fixed = (syn != 6'h00) && (syn <= 6'(CW_BITS));

  genvar j;
  generate
    for (j = 0; j < CW_BITS; j++) begin : g_fix
      assign fix_cw[j] = raw_cw[j] ^ (dec_fixed && (syn == 6'(j + 1)));
    end
  endgenerate

  assign dec_data = extract(fix_cw);
endmodule

// *** verif/spi_host_model.sv ***
// host-side serial master driving the eeprom pins in mode 0 or 3
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  localparam int HALF = 10;
  logic hold_oe;
  logic cpol;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    hold_oe = 1'b0;
    cpol = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // idle level of the serial clock, changed only between frames
  task automatic set_mode(input logic idle);
    @(posedge core_clk);
    cpol = idle;
    sck <= idle;
    ticks(4);
  endtask

  task automatic open_frame();
    @(posedge core_clk);
    cs_n <= 1'b0;
    ticks(4);
  endtask

  // si flips once deselected so a stale bit is never mistaken for data
  task automatic close_frame();
    ticks(4);
    cs_n <= 1'b1;
    si <= ~si;
    ticks(10);
  endtask

  // sck low at both edges; the pulse in between must be ignored
  task automatic pause();
    hold_n <= 1'b0;
    ticks(6);
    hold_oe = so_oe;
    sck <= 1'b1;
    si <= ~si;
    ticks(HALF);
    sck <= 1'b0;
    ticks(HALF);
    hold_n <= 1'b1;
    ticks(6);
  endtask

  // data set while sck low, reply sampled at the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int pause_bit);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      sck <= 1'b0;
      si <= tx[i];
      ticks(HALF);
      sck <= 1'b1;
      rx[i] = so_oe ? so : 1'bx;
      ticks(HALF);
      sck <= cpol;
      if (i == pause_bit) begin
        ticks(HALF);
        pause();
      end
    end
  endtask
endmodule

// *** verif/spi_eeprom_command_interface_bench.sv ***
// self-checking bench for the serial eeprom command interface
`timescale 1ns/1ps
module spi_eeprom_command_interface_bench
  import eeprom_spi_pkg::*;
;
  // long enough that a status read plus a command fit inside one cycle
  localparam int WC = 1000;
  localparam int PWR_UP_CYC = 64;
  logic core_clk, rst_n, wp_n, cs_n, sck, si, hold_n, so, so_oe;
  logic [14:0] mem_raddr, mem_waddr;
  logic mem_rid, mem_we, mem_wid, write_busy, last_wid, oe_seen;
  logic [7:0] status, rx, st;
  ecc_word_s mem_rdata, mem_wdata;
  ecc_word_s mem [0:65535];
  logic [7:0] wb [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h96};
  int we_count = 0;
  int err_count, num_checks, cnt;

  spi_eeprom_cmd #(.WC_CYC(WC)) i_spi_eeprom_cmd (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .mem_raddr(mem_raddr), .mem_rid(mem_rid), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wid(mem_wid),
    .mem_wdata(mem_wdata), .status(status), .write_busy(write_busy));

  spi_host_model i_spi_host_model (
    .core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so(so), .so_oe(so_oe));

  assign mem_rdata = mem[{mem_rid, mem_raddr}];

  always @(posedge core_clk) begin
    if (mem_we === 1'b1) begin
      mem[{mem_wid, mem_waddr}] <= mem_wdata;
      we_count <= we_count + 1;
      last_wid <= mem_wid;
    end
    if (so_oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic xb(input logic [7:0] tx);
    i_spi_host_model.xfer(tx, rx, -1);
  endtask

  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.open_frame();
    xb(op);
    i_spi_host_model.close_frame();
  endtask

  task automatic rd_stat();
    i_spi_host_model.open_frame();
    xb(OP_RD_STAT);
    i_spi_host_model.xfer(8'h00, st, -1);
    i_spi_host_model.close_frame();
  endtask

  task automatic send_addr(input logic [7:0] op, input logic [23:0] a);
    i_spi_host_model.open_frame();
    xb(op);
    xb(a[23:16]);
    xb(a[15:8]);
    xb(a[7:0]);
  endtask

  task automatic wr_stat(input logic [7:0] v);
    cmd(OP_SET_LATCH);
    i_spi_host_model.open_frame();
    xb(OP_WR_STAT);
    xb(v);
    i_spi_host_model.close_frame();
  endtask

  task automatic wait_idle();
    cnt = 0;
    while (write_busy !== 1'b0 && cnt < 2 * WC) begin
      @(posedge core_clk);
      cnt++;
    end
    if (write_busy !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: write cycle never ended", $time);
    end
  endtask

  task automatic sc_reset();
    check(status, 8'h00, "status after reset");
    check(so_oe, 1'b0, "so driven while deselected");
    rd_stat();
    check(st, 8'h00, "status read");
  endtask

  task automatic sc_latch();
    cmd(OP_SET_LATCH);
    rd_stat();
    check(st, 8'h02, "latch set");
    cmd(OP_CLR_LATCH);
    rd_stat();
    check(st, 8'h00, "latch cleared");
  endtask

  // idle-high serial clock: each bit opens with a fall
  task automatic sc_mode3();
    i_spi_host_model.set_mode(1'b1);
    cmd(OP_SET_LATCH);
    rd_stat();
    check(st, 8'h02, "status in mode 3");
    cmd(OP_CLR_LATCH);
    i_spi_host_model.set_mode(1'b0);
  endtask

  // near-miss codes catch a partial opcode compare
  task automatic sc_bad_opcode();
    logic [7:0] bad [3] = '{8'h86, 8'h07, 8'hff};
    for (int k = 0; k < 3; k++) begin
      oe_seen = 1'b0;
      i_spi_host_model.open_frame();
      xb(bad[k]);
      xb(OP_SET_LATCH);
      xb(OP_RD_STAT);
      i_spi_host_model.close_frame();
      check(oe_seen, 1'b0, "output after unknown opcode");
      rd_stat();
      check(st, 8'h00, "unknown opcode acted");
    end
  endtask

  task automatic sc_hold();
    cmd(OP_SET_LATCH);
    i_spi_host_model.open_frame();
    i_spi_host_model.xfer(OP_RD_STAT, rx, 3);
    i_spi_host_model.xfer(8'h00, st, 4);
    i_spi_host_model.close_frame();
    check(st, 8'h02, "status across pause");
    check(i_spi_host_model.hold_oe, 1'b0, "so during pause");
    cmd(OP_CLR_LATCH);
  endtask

  task automatic sc_write_read();
    int n;
    n = we_count;
    send_addr(OP_WR_MEM, 24'hfe0104);
    for (int k = 0; k < 4; k++) xb(wb[k]);
    i_spi_host_model.close_frame();
    check(we_count, n, "write without latch");
    check(write_busy, 1'b0, "busy without latch");
    cmd(OP_SET_LATCH);
    send_addr(OP_WR_MEM, 24'hfe0104);
    for (int k = 0; k < 4; k++) xb(wb[k]);
    i_spi_host_model.close_frame();
    check(we_count, n + 1, "group writes");
    check(mem[16'h0041].data, 32'h960f3ca5, "group data");
    rd_stat();
    check(st[0], 1'b1, "busy bit");
    cmd(OP_SET_LATCH);
    wait_idle();
    check(cnt > 0 && cnt <= WC, 1'b1, "write cycle length");
    rd_stat();
    check(st, 8'h00, "latch after write cycle");
    send_addr(OP_RD_MEM, 24'h020104);
    for (int k = 0; k < 4; k++) begin
      i_spi_host_model.xfer(8'h00, rx, -1);
      check(rx, wb[k], "read data");
    end
    i_spi_host_model.close_frame();
    mem[16'h0041].data[9] = ~mem[16'h0041].data[9];
    send_addr(OP_RD_MEM, 24'h000105);
    i_spi_host_model.xfer(8'h00, rx, -1);
    check(rx, wb[1], "single-bit error corrected");
    i_spi_host_model.close_frame();
  endtask

  task automatic sc_protect();
    wr_stat(8'h80);
    wait_idle();
    rd_stat();
    check(st & 8'hfd, 8'h80, "enable written, pin high");
    @(posedge core_clk);
    wp_n <= 1'b0;
    wr_stat(8'h8c);
    wait_idle();
    rd_stat();
    check(st & 8'hfd, 8'h80, "status write protected");
    @(posedge core_clk);
    wp_n <= 1'b1;
    wr_stat(8'h0c);
    wait_idle();
    rd_stat();
    check(st & 8'hfd, 8'h0c, "status write pin high");
    wr_stat(8'h00);
    wait_idle();
  endtask

  task automatic sc_id_page();
    wr_stat(8'h40);
    wait_idle();
    rd_stat();
    check(st & 8'hfd, 8'h40, "page select set");
    cmd(OP_SET_LATCH);
    send_addr(OP_WR_MEM, 24'h000310);
    for (int k = 0; k < 4; k++) xb(wb[k]);
    i_spi_host_model.close_frame();
    check(last_wid, 1'b1, "id page target");
    check(mem[16'h8004].data, 32'h960f3ca5, "id page data");
    wait_idle();
    rd_stat();
    check(st, 8'h00, "page select after access");
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    err_count = 0;
    num_checks = 0;
    oe_seen = 1'b0;
    last_wid = 1'b0;
    for (int k = 0; k < 65536; k++) mem[k] = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (PWR_UP_CYC) @(posedge core_clk);
    sc_reset();
    sc_latch();
    sc_mode3();
    sc_bad_opcode();
    sc_hold();
    sc_write_read();
    sc_protect();
    sc_id_page();
    results();
  end

  // the tests need about 23000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    results();
  end
endmodule
